// ---- cpu_ops_defs.svh ----
`ifndef CPU_OPS_DEFS_SVH
`define CPU_OPS_DEFS_SVH
// status flag bit positions
`define FL_C 3'h0
`define FL_Z 3'h1
`define FL_N 3'h2
`define FL_V 3'h3
`define FL_S 3'h4
`define FL_H 3'h5
`define FL_T 3'h6
`define FL_I 3'h7
`define FLAGS_RST 8'h00
// pointer pair low registers
`define PTR_FIRST_LO 5'h1a
`define PTR_SECOND_LO 5'h1c
`define PTR_THIRD_LO 5'h1e
// avalon byte offsets
`define OFS_FLAGS 8'h00
`define OFS_STATE 8'h04
`define OFS_GPR 8'h80
`define STATE_BUSY 0
`define STATE_STORE 1
`endif

// ---- cpu_ops_pkg.sv ----
package cpu_ops_pkg;
   typedef enum logic [4:0] {
      op_nop = 5'h00,
      op_rotate_right_carry = 5'h01,
      op_arith_shift_right = 5'h02,
      op_nibble_swap = 5'h03,
      op_copy_bit_to_tflag = 5'h04,
      op_bit_from_tflag = 5'h05,
      op_flag_set = 5'h06,
      op_flag_clear = 5'h07,
      op_register_copy = 5'h08,
      op_register_pair_copy = 5'h09,
      op_load_constant = 5'h0a,
      op_load_indirect = 5'h0b,
      op_load_displaced = 5'h0c,
      op_load_direct = 5'h0d,
      op_memory_write_indirect = 5'h0e
   } op_t;
   typedef enum logic [1:0] {
      ptr_first = 2'h0,
      ptr_second = 2'h1,
      ptr_third = 2'h2
   } ptr_t;
   typedef enum logic [1:0] {
      am_plain = 2'h0,
      am_post_inc = 2'h1,
      am_pre_dec = 2'h2
   } amode_t;
   typedef enum logic {
      fsm_idle = 1'b0,
      fsm_access = 1'b1
   } fsm_t;
   typedef struct packed {
      op_t op;
      logic [4:0] rd;
      logic [4:0] src;
      logic [2:0] bitsel;
      logic [7:0] imm;
      ptr_t ptr;
      amode_t mode;
      logic [5:0] disp;
      logic [15:0] addr;
   } instr_t;
   typedef struct packed {
      logic re;
      logic we;
      logic [15:0] addr;
      logic [7:0] wdata;
   } dmem_t;
endpackage

// ---- cpu_shift_flag_load_store_ops.sv ----
`timescale 1ns/100ps
`include "cpu_ops_defs.svh"
// Overview of operation
// RQ1 - rotate right through carry, one clock
// RQ2 - arithmetic shift right keeps bit 7
// RQ3 - copy register bit into t flag
// RQ4 - write t flag into register bit
// RQ5 - set one status flag, one clock
// RQ6 - clear one status flag, one clock
// RQ7 - set and clear overflow flag only
// RQ8 - set and clear sign test flag
// RQ9 - first pointer load, then increment
// RQ10 - first pointer decrement, then load
// RQ11 - load at second/third pointer plus displacement
// RQ12 - load at direct address, two clocks
// RQ13 - first pointer store, then increment
// RQ14 - first pointer decrement, then store
// RQ15 - third pointer decrement, then load
// RQ16 - second pointer load, then increment
// RQ17 - second pointer store, then increment
// RQ18 - swap nibbles, flags untouched
// RQ19 - copy, pair copy, constant load
// RQ20 - interrupt enable flag set and clear
module cpu_shift_flag_load_store_ops
   import cpu_ops_pkg::*;
(
   input wire logic mclk,
   input wire logic rst,
   input wire logic ce,
   input wire logic instr_valid,
   input wire instr_t instr,
   output logic instr_ready,
   output dmem_t dmem,
   input wire logic [7:0] dmem_rdata,
   input wire logic [7:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest
);
   typedef struct packed {
      fsm_t fsm;
      logic [31:0][7:0] gpr;
      logic [7:0] flags;
      logic [15:0] maddr;
      logic [7:0] mwdata;
      logic mwe;
      logic [4:0] mdst;
      logic rd_ack;
      logic [31:0] rdata;
   } state_t;

   state_t r;
   state_t next_r;
   logic fire;
   logic bus_wr_ok;
   logic [4:0] pidx;
   logic [15:0] ptr_val;
   logic [15:0] ptr_inc;
   logic [15:0] ptr_dec;
   logic [15:0] mem_addr;
   logic [7:0] rd_val;
   logic [7:0] src_val;
   logic [7:0] rot_res;
   logic [7:0] ashr_res;
   logic [7:0] swap_res;
   logic [7:0] flag_mask;
   logic t_src;

   function automatic logic [4:0] ptr_lo(ptr_t p);
      unique case (p)
         ptr_first: ptr_lo = `PTR_FIRST_LO;
         ptr_second: ptr_lo = `PTR_SECOND_LO;
         default: ptr_lo = `PTR_THIRD_LO;
      endcase
   endfunction

   function automatic logic [15:0] ptr_word(logic [31:0][7:0] g,
                                            logic [4:0] lo);
      ptr_word = {g[{lo[4:1], 1'b1}], g[{lo[4:1], 1'b0}]};
   endfunction

   function automatic logic [7:0] shift_flags(logic [7:0] f,
                                              logic [7:0] res,
                                              logic c);
      logic [7:0] o;
      o = f;
      o[`FL_Z] = (res == 8'h00);
      o[`FL_C] = c;
      o[`FL_N] = res[7];
      o[`FL_V] = res[7] ^ c;
      o[`FL_S] = o[`FL_N] ^ o[`FL_V];
      shift_flags = o;
   endfunction

   function automatic logic [31:0] bus_word(state_t s, logic [7:0] a);
      bus_word = 32'h0000_0000;
      if (a[7])
         bus_word = {24'h000000, s.gpr[a[6:2]]};
      else if (a == `OFS_FLAGS)
         bus_word = {24'h000000, s.flags};
      else if (a == `OFS_STATE)
      begin
         bus_word[`STATE_BUSY] = (s.fsm == fsm_access);
         bus_word[`STATE_STORE] = (s.fsm == fsm_access) && s.mwe;
      end
   endfunction

   assign instr_ready = ce && (r.fsm == fsm_idle);
   assign fire = instr_valid && instr_ready;
   assign bus_wr_ok = instr_ready && !instr_valid;
   assign avs_waitrequest = avs_read ? !r.rd_ack :
                            (avs_write ? !bus_wr_ok : 1'b0);
   assign avs_readdata = r.rdata;
   assign dmem.re = (r.fsm == fsm_access) && !r.mwe;
   assign dmem.we = (r.fsm == fsm_access) && r.mwe;
   assign dmem.addr = r.maddr;
   assign dmem.wdata = r.mwdata;

   assign pidx = ptr_lo(instr.ptr);
   assign ptr_val = ptr_word(r.gpr, pidx);
   assign ptr_inc = ptr_val + 16'h0001;
   assign ptr_dec = ptr_val - 16'h0001;
   assign rd_val = r.gpr[instr.rd];
   assign src_val = r.gpr[instr.src];
   assign rot_res = {r.flags[`FL_C], rd_val[7:1]};
   assign ashr_res = {rd_val[7], rd_val[7:1]};
   assign swap_res = {rd_val[3:0], rd_val[7:4]};
   assign flag_mask = 8'h01 << instr.bitsel;
   assign t_src = src_val[instr.bitsel];

   always_comb
   begin
      mem_addr = ptr_val;
      unique case (instr.op)
         op_load_displaced: mem_addr = ptr_val + {10'h000, instr.disp}; // RQ11
         op_load_direct: mem_addr = instr.addr; // RQ12
         default:
         begin
            if (instr.mode == am_pre_dec)
               mem_addr = ptr_dec; // RQ10 RQ14 RQ15
         end
      endcase
   end

   always_comb
   begin
      next_r = r;
      next_r.rd_ack = avs_read && !r.rd_ack;
      if (avs_read && !r.rd_ack)
         next_r.rdata = bus_word(r, avs_address);
      if (r.fsm == fsm_access)
      begin
         next_r.fsm = fsm_idle;
         if (!r.mwe)
            next_r.gpr[r.mdst] = dmem_rdata; // RQ9 RQ10 RQ12 RQ15 RQ16
      end
      if (fire)
      begin
         unique case (instr.op)
            op_rotate_right_carry:
            begin
               next_r.gpr[instr.rd] = rot_res; // RQ1
               next_r.flags = shift_flags(r.flags, rot_res, rd_val[0]); // RQ1
            end
            op_arith_shift_right:
            begin
               next_r.gpr[instr.rd] = ashr_res; // RQ2
               next_r.flags = shift_flags(r.flags, ashr_res, rd_val[0]); // RQ2
            end
            op_nibble_swap: next_r.gpr[instr.rd] = swap_res; // RQ18
            op_copy_bit_to_tflag: next_r.flags[`FL_T] = t_src; // RQ3
            op_bit_from_tflag:
               next_r.gpr[instr.rd][instr.bitsel] = r.flags[`FL_T]; // RQ4
            op_flag_set:
               next_r.flags = r.flags | flag_mask; // RQ5 RQ7 RQ8 RQ20
            op_flag_clear:
               next_r.flags = r.flags & ~flag_mask; // RQ6 RQ7 RQ8 RQ20
            op_register_copy: next_r.gpr[instr.rd] = src_val; // RQ19
            op_register_pair_copy:
            begin
               next_r.gpr[{instr.rd[4:1], 1'b0}] =
                  r.gpr[{instr.src[4:1], 1'b0}]; // RQ19
               next_r.gpr[{instr.rd[4:1], 1'b1}] =
                  r.gpr[{instr.src[4:1], 1'b1}]; // RQ19
            end
            op_load_constant: next_r.gpr[instr.rd] = instr.imm; // RQ19
            op_load_indirect, op_load_displaced, op_load_direct,
            op_memory_write_indirect:
            begin
               next_r.fsm = fsm_access;
               next_r.maddr = mem_addr;
               next_r.mwe = (instr.op == op_memory_write_indirect);
               next_r.mwdata = src_val; // RQ13 RQ14 RQ17
               next_r.mdst = instr.rd;
               if ((instr.op == op_load_indirect ||
                    instr.op == op_memory_write_indirect) &&
                   instr.mode != am_plain)
               begin
                  if (instr.mode == am_pre_dec)
                  begin
                     next_r.gpr[pidx] = ptr_dec[7:0]; // RQ10 RQ14 RQ15
                     next_r.gpr[{pidx[4:1], 1'b1}] = ptr_dec[15:8];
                  end
                  else
                  begin
                     next_r.gpr[pidx] = ptr_inc[7:0]; // RQ9 RQ13 RQ16 RQ17
                     next_r.gpr[{pidx[4:1], 1'b1}] = ptr_inc[15:8];
                  end
               end
            end
            default:
            begin
               next_r.fsm = r.fsm;
            end
         endcase
      end
      if (avs_write && bus_wr_ok)
      begin
         if (avs_address[7])
            next_r.gpr[avs_address[6:2]] = avs_writedata[7:0];
         else if (avs_address == `OFS_FLAGS)
            next_r.flags = avs_writedata[7:0];
      end
   end

   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         r <= '{fsm: fsm_idle, flags: `FLAGS_RST, default: '0};
      end
      else if (ce)
      begin
         r <= next_r;
      end
   end

   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (rst);

   logic [7:0] flags_now;
   logic load_fire;
   logic post_fire;
   logic pre_fire;
   assign flags_now = r.flags;
   assign load_fire = fire && (instr.op == op_load_indirect ||
                               instr.op == op_load_displaced ||
                               instr.op == op_load_direct);
   assign post_fire = fire && instr.mode == am_post_inc &&
                      (instr.op == op_load_indirect ||
                       instr.op == op_memory_write_indirect);
   assign pre_fire = fire && instr.mode == am_pre_dec &&
                     (instr.op == op_load_indirect ||
                      instr.op == op_memory_write_indirect);

   a_rotate_result: assert property ( // RQ1
      fire && instr.op == op_rotate_right_carry |=>
      r.gpr[$past(instr.rd)] == $past(rot_res) &&
      r.flags[`FL_C] == $past(rd_val[0]) &&
      r.flags[`FL_Z] == ($past(rot_res) == 8'h00))
      else $error("rotate result or carry wrong");

   a_shift_keeps_msb: assert property ( // RQ2
      fire && instr.op == op_arith_shift_right |=>
      r.gpr[$past(instr.rd)][7] == $past(rd_val[7]) &&
      r.gpr[$past(instr.rd)][6:0] == $past(rd_val[7:1]) &&
      r.flags[`FL_C] == $past(rd_val[0]))
      else $error("arithmetic shift wrong");

   a_tflag_store: assert property ( // RQ3
      fire && instr.op == op_copy_bit_to_tflag |=>
      r.flags[`FL_T] == $past(t_src) &&
      r.flags[5:0] == $past(flags_now[5:0]) &&
      r.flags[`FL_I] == $past(flags_now[7]))
      else $error("t flag store wrong");

   a_tflag_load: assert property ( // RQ4
      fire && instr.op == op_bit_from_tflag |=>
      r.flags == $past(flags_now) &&
      r.gpr[$past(instr.rd)][$past(instr.bitsel)] == r.flags[`FL_T])
      else $error("t flag load wrong");

   a_flag_set_only: assert property ( // RQ5
      fire && instr.op == op_flag_set |=>
      r.flags == ($past(flags_now) | $past(flag_mask)))
      else $error("flag set touched other flags");

   a_flag_clear_only: assert property ( // RQ6
      fire && instr.op == op_flag_clear |=>
      r.flags == ($past(flags_now) & ~$past(flag_mask)))
      else $error("flag clear touched other flags");

   a_load_two_clk: assert property ( // RQ12
      load_fire |=> dmem.re && !dmem.we &&
      dmem.addr == $past(mem_addr) && !instr_ready)
      else $error("load access not in second clock");

   a_load_capture: assert property ( // RQ9
      dmem.re && ce |=> r.fsm == fsm_idle &&
      r.gpr[$past(r.mdst)] == $past(dmem_rdata) &&
      r.flags == $past(flags_now))
      else $error("loaded byte not written");

   a_post_inc_ptr: assert property ( // RQ13
      post_fire |=> dmem.addr == $past(ptr_val) &&
      ptr_word(r.gpr, $past(pidx)) == $past(ptr_inc))
      else $error("post increment wrong");

   a_pre_dec_ptr: assert property ( // RQ14
      pre_fire |=> dmem.addr == $past(ptr_dec) &&
      ptr_word(r.gpr, $past(pidx)) == dmem.addr)
      else $error("pre decrement wrong");

   a_swap_nibbles: assert property ( // RQ18
      fire && instr.op == op_nibble_swap |=>
      r.gpr[$past(instr.rd)] == $past(swap_res) &&
      r.flags == $past(flags_now))
      else $error("nibble swap wrong");

   a_store_write: assert property ( // RQ17
      fire && instr.op == op_memory_write_indirect |=>
      dmem.we && !dmem.re && dmem.wdata == $past(src_val) &&
      r.flags == $past(flags_now))
      else $error("store access wrong");

   a_pair_copy: assert property ( // RQ19
      fire && instr.op == op_register_pair_copy |=>
      r.gpr[{$past(instr.rd[4:1]), 1'b0}] ==
      $past(r.gpr[{instr.src[4:1], 1'b0}]) &&
      r.gpr[{$past(instr.rd[4:1]), 1'b1}] ==
      $past(r.gpr[{instr.src[4:1], 1'b1}]))
      else $error("pair copy wrong");

   a_disp_addr: assert property ( // RQ11
      fire && instr.op == op_load_displaced |=>
      dmem.addr == $past(ptr_val) + 16'($past(instr.disp)) &&
      ptr_word(r.gpr, $past(pidx)) == $past(ptr_val))
      else $error("displacement address wrong");

   c_rotate: cover property (fire && instr.op == op_rotate_right_carry);
   c_post_load: cover property (post_fire && load_fire ##2 instr_ready);
   c_pre_store: cover property (pre_fire && !load_fire ##1 dmem.we);
   c_bus_read: cover property (avs_read && !avs_waitrequest);
endmodule // cpu_shift_flag_load_store_ops

// ---- dmem_model.sv ----
`timescale 1ns/100ps
module dmem_model
   import cpu_ops_pkg::*;
(
   input wire logic mclk,
   input wire dmem_t dmem,
   output logic [7:0] rdata
);
   logic [7:0] mem [0:255];
   logic [7:0] last = 8'h00;
   initial
   begin
      for (int i = 0; i < 256; i++)
         mem[i] = 8'(i) ^ 8'h5a;
   end
   // unselected read port shows inverse of last byte
   assign rdata = dmem.re ? mem[dmem.addr[7:0]] : ~last;
   always @(posedge mclk)
   begin
      if (dmem.re)
         last <= mem[dmem.addr[7:0]];
      if (dmem.we)
         mem[dmem.addr[7:0]] <= dmem.wdata;
   end
endmodule // dmem_model

// ---- cpu_shift_flag_load_store_ops_bench.sv ----
`timescale 1ns/100ps
module cpu_shift_flag_load_store_ops_bench
   import cpu_ops_pkg::*;
;
   logic mclk = 1'b0;
   logic rst = 1'b1;
   logic ce = 1'b1;
   logic instr_valid = 1'b0;
   instr_t instr = '0;
   logic instr_ready;
   dmem_t dmem;
   dmem_t seen;
   logic rdy_seen;
   logic [7:0] rdata;
   logic [7:0] avs_address = 8'h00;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = '0;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   int n_errors = 0;
   int n_checks = 0;
   int cycles = 0;

   always #5 mclk = ~mclk;

   cpu_shift_flag_load_store_ops u_dut (.mclk(mclk), .rst(rst), .ce(ce),
      .instr_valid(instr_valid), .instr(instr), .instr_ready(instr_ready),
      .dmem(dmem), .dmem_rdata(rdata), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest));
   dmem_model u_mem (.mclk(mclk), .dmem(dmem), .rdata(rdata));

   task automatic results();
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   always @(posedge mclk)
   begin
      cycles <= cycles + 1;
      if (cycles == 20000)
      begin
         n_errors = n_errors + 1;
         results();
      end
   end

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         n_errors++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic bus(input logic wr, input logic [7:0] a,
      input logic [7:0] d, output logic [31:0] q);
      @(posedge mclk);
      avs_address <= a;
      avs_writedata <= {24'h0, d};
      avs_read <= ~wr;
      avs_write <= wr;
      do @(posedge mclk); while (avs_waitrequest !== 1'b0);
      q = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask

   task automatic expect_reg(input logic [7:0] a, input logic [7:0] e);
      logic [31:0] q;
      bus(1'b0, a, 8'h00, q);
      check(q, {24'h0, e});
   endtask

   function automatic logic [7:0] gp(input logic [4:0] n);
      return 8'h80 + {1'b0, n, 2'b00};
   endfunction

   function automatic instr_t mk(input op_t o, input logic [4:0] d,
      input logic [4:0] s, input logic [7:0] k);
      mk = '0;
      mk.op = o;
      mk.rd = d;
      mk.src = s;
      mk.bitsel = k[2:0];
      mk.imm = k;
      mk.disp = k[5:0];
      mk.addr = {8'h00, k};
   endfunction

   function automatic instr_t mm(input op_t o, input ptr_t p,
      input amode_t m, input logic [4:0] r, input logic [7:0] k);
      mm = mk(o, r, r, k);
      mm.ptr = p;
      mm.mode = m;
   endfunction

   task automatic issue(input instr_t i);
      @(posedge mclk);
      instr <= i;
      instr_valid <= 1'b1;
      do @(posedge mclk); while (instr_ready !== 1'b1);
      instr_valid <= 1'b0;
      @(negedge mclk);
      seen = dmem;
      rdy_seen = instr_ready;
      while (instr_ready !== 1'b1)
         @(negedge mclk);
   endtask

   task automatic put(input logic [4:0] n, input logic [7:0] k);
      issue(mk(op_load_constant, n, 5'd0, k));
   endtask

   task automatic mem_seen(input logic w, input logic [7:0] a,
      input logic [7:0] d);
      check({rdy_seen, seen.re, seen.we, seen.addr}, {1'b0, ~w, w, 8'h00, a});
      if (w)
         check(seen.wdata, d);
   endtask

   task automatic t_shift();
      put(5'd16, 8'h81);
      issue(mk(op_flag_set, 5'd0, 5'd0, 8'h00));
      issue(mk(op_rotate_right_carry, 5'd16, 5'd0, 8'h00));
      check(rdy_seen, 1'b1);
      expect_reg(gp(5'd16), 8'hc0);
      expect_reg(8'h00, 8'h15);
      issue(mk(op_arith_shift_right, 5'd16, 5'd0, 8'h00));
      expect_reg(gp(5'd16), 8'he0);
      expect_reg(8'h00, 8'h0c);
      put(5'd17, 8'h01);
      issue(mk(op_arith_shift_right, 5'd17, 5'd0, 8'h00));
      expect_reg(gp(5'd17), 8'h00);
      expect_reg(8'h00, 8'h1b);
   endtask

   task automatic t_bits();
      put(5'd17, 8'h3c);
      issue(mk(op_nibble_swap, 5'd17, 5'd0, 8'h00));
      expect_reg(gp(5'd17), 8'hc3);
      expect_reg(8'h00, 8'h1b);
      issue(mk(op_copy_bit_to_tflag, 5'd0, 5'd17, 8'h07));
      expect_reg(8'h00, 8'h5b);
      issue(mk(op_bit_from_tflag, 5'd18, 5'd0, 8'h02));
      expect_reg(gp(5'd18), 8'h04);
      expect_reg(8'h00, 8'h5b);
      issue(mk(op_copy_bit_to_tflag, 5'd0, 5'd17, 8'h02));
      expect_reg(8'h00, 8'h1b);
   endtask

   task automatic t_flags();
      logic [31:0] q;
      logic [7:0] e;
      bus(1'b1, 8'h00, 8'h00, q);
      e = 8'h00;
      for (int b = 0; b < 8; b++)
      begin
         issue(mk(op_flag_set, 5'd0, 5'd0, 8'(b)));
         e[b] = 1'b1;
         expect_reg(8'h00, e);
      end
      for (int b = 0; b < 8; b++)
      begin
         issue(mk(op_flag_clear, 5'd0, 5'd0, 8'(b)));
         e[b] = 1'b0;
         expect_reg(8'h00, e);
      end
   endtask

   task automatic t_copy();
      logic [31:0] q;
      bus(1'b1, gp(5'd0), 8'ha5, q);
      bus(1'b1, gp(5'd1), 8'h5a, q);
      bus(1'b1, 8'h44, 8'hff, q);
      issue(mk(op_register_pair_copy, 5'd2, 5'd0, 8'h00));
      issue(mk(op_register_copy, 5'd4, 5'd1, 8'h00));
      expect_reg(gp(5'd2), 8'ha5);
      expect_reg(gp(5'd3), 8'h5a);
      expect_reg(gp(5'd4), 8'h5a);
      expect_reg(8'h44, 8'h00);
      expect_reg(8'h04, 8'h00);
   endtask

   task automatic t_mem();
      put(5'd26, 8'h10);
      put(5'd27, 8'h00);
      issue(mm(op_load_indirect, ptr_first, am_post_inc, 5'd5, 8'h00));
      mem_seen(1'b0, 8'h10, 8'h00);
      expect_reg(gp(5'd5), 8'h4a);
      expect_reg(gp(5'd26), 8'h11);
      issue(mm(op_load_indirect, ptr_first, am_pre_dec, 5'd6, 8'h00));
      mem_seen(1'b0, 8'h10, 8'h00);
      expect_reg(gp(5'd6), 8'h4a);
      expect_reg(gp(5'd26), 8'h10);
      issue(mm(op_memory_write_indirect, ptr_first, am_post_inc, 5'd4, 8'h00));
      mem_seen(1'b1, 8'h10, 8'h5a);
      expect_reg(gp(5'd26), 8'h11);
      issue(mm(op_memory_write_indirect, ptr_first, am_pre_dec, 5'd2, 8'h00));
      mem_seen(1'b1, 8'h10, 8'ha5);
      expect_reg(gp(5'd26), 8'h10);
      put(5'd28, 8'h20);
      put(5'd29, 8'h00);
      issue(mm(op_memory_write_indirect, ptr_second, am_post_inc, 5'd3, 8'h00));
      mem_seen(1'b1, 8'h20, 8'h5a);
      issue(mm(op_load_indirect, ptr_second, am_post_inc, 5'd8, 8'h00));
      mem_seen(1'b0, 8'h21, 8'h00);
      expect_reg(gp(5'd8), 8'h7b);
      expect_reg(gp(5'd28), 8'h22);
      put(5'd30, 8'h31);
      put(5'd31, 8'h00);
      issue(mm(op_load_indirect, ptr_third, am_pre_dec, 5'd9, 8'h00));
      expect_reg(gp(5'd9), 8'h6a);
      expect_reg(gp(5'd30), 8'h30);
      issue(mm(op_load_displaced, ptr_third, am_plain, 5'd10, 8'h05));
      mem_seen(1'b0, 8'h35, 8'h00);
      expect_reg(gp(5'd10), 8'h6f);
      expect_reg(gp(5'd30), 8'h30);
      issue(mk(op_load_direct, 5'd11, 5'd0, 8'h20));
      mem_seen(1'b0, 8'h20, 8'h00);
      expect_reg(gp(5'd11), 8'h5a);
      expect_reg(8'h00, 8'h00);
   endtask

   task automatic t_freeze();
      @(posedge mclk);
      ce <= 1'b0;
      instr <= mk(op_load_constant, 5'd12, 5'd0, 8'h11);
      instr_valid <= 1'b1;
      repeat (3) @(posedge mclk);
      @(negedge mclk);
      check(instr_ready, 1'b0);
      @(posedge mclk);
      ce <= 1'b1;
      do @(posedge mclk); while (instr_ready !== 1'b1);
      instr_valid <= 1'b0;
      expect_reg(gp(5'd12), 8'h11);
   endtask

   initial
   begin
      repeat (4) @(posedge mclk);
      rst <= 1'b0;
      t_shift();
      t_bits();
      t_flags();
      t_copy();
      t_mem();
      t_freeze();
      results();
   end
endmodule // cpu_shift_flag_load_store_ops_bench
